// File: src/irq_core_end.sv
// processor core end: issues register accesses and services interrupts
// assumes a plain software port with read data one cycle after the read strobe
`timescale 1ns/10ps
module irq_core_end
  import irq_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // software port
  input  wire logic [3:0] sw_addr,
  input  wire logic [7:0] sw_wdata,
  input  wire logic       sw_wr,
  input  wire logic       sw_rd,
  output logic      [7:0] sw_rdata,
  // link to the controller
  irq_link_if.core        link
);

  typedef struct packed {
    core_state_t  st;
    logic [11:0]  cmd_addr;
    logic [7:0]   cmd_wdata;
    logic         cmd_write;
    logic         cmd_pend;
    logic [7:0]   cmd_rdata;
    logic         auto_svc;
    logic [23:0]  flags;
    logic [7:0]   svc_count;
    logic [4:0]   last_id;
    logic [11:0]  bus_addr;
    logic [7:0]   bus_wdata;
    logic         bus_wr;
    logic         bus_rd;
    logic [7:0]   sw_rdata;
  } core_regs_t;

  core_regs_t q, d;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d        = q;
    d.bus_wr = 1'b0;
    d.bus_rd = 1'b0;

    if (sw_wr) begin
      case (sw_addr)
        HOFS_ADDR_LO:  d.cmd_addr[7:0]  = sw_wdata;
        HOFS_ADDR_HI:  d.cmd_addr[11:8] = sw_wdata[3:0];
        HOFS_WDATA:    d.cmd_wdata      = sw_wdata;
        HOFS_CMD: begin
          if (sw_wdata[CMD_GO_BIT]) begin
            d.cmd_pend  = 1'b1;
            d.cmd_write = sw_wdata[CMD_WRITE_BIT];
          end
        end
        HOFS_SVC_CTRL: d.auto_svc = sw_wdata[0];
        default: ;
      endcase
    end

    case (q.st)
      CORE_IDLE: begin
        // a queued command goes first so software is never starved by a held level source
        if (q.cmd_pend) begin
          d.st        = q.cmd_write ? CORE_IDLE : CORE_CMD;
          d.cmd_pend  = 1'b0;
          d.bus_addr  = q.cmd_addr;
          d.bus_wdata = q.cmd_wdata;
          d.bus_wr    = q.cmd_write;
          d.bus_rd    = ~q.cmd_write;
        // a clear still on the link leaves irq high one more cycle; wait it out to avoid a second service
        end else if (q.auto_svc && link.irq && !q.bus_wr) begin
          d.st       = SVC_RD0;
          d.last_id  = link.irq_id;
        end
      end
      CORE_CMD:  d.st = CORE_RDW;
      CORE_RDW: begin
        d.cmd_rdata = link.rdata;
        d.st        = CORE_IDLE;
      end
      SVC_RD0: begin
        d.bus_addr = OFS_SOURCE_FLAGS0;
        d.bus_rd   = 1'b1;
        d.st       = SVC_RD1;
      end
      SVC_RD1: begin
        d.bus_addr = OFS_SOURCE_FLAGS1;
        d.bus_rd   = 1'b1;
        d.st       = SVC_RD2;
      end
      SVC_RD2: begin
        d.flags[7:0] = link.rdata;
        d.bus_addr   = OFS_SOURCE_FLAGS2;
        d.bus_rd     = 1'b1;
        d.st         = SVC_RDW;
      end
      SVC_RDW: begin
        d.flags[15:8] = link.rdata;
        d.st          = SVC_CLR;
      end
      SVC_CLR: begin
        // edge flags go by write-one; level flags are left to their own modules
        d.flags[23:16] = link.rdata;
        d.bus_addr     = OFS_SOURCE_FLAGS2;
        d.bus_wdata    = link.rdata;
        d.bus_wr       = |link.rdata;
        d.svc_count    = q.svc_count + 8'h01;
        d.st           = CORE_IDLE;
      end
      default: d.st = CORE_IDLE;
    endcase

    case (sw_addr)
      HOFS_ADDR_LO:   d.sw_rdata = q.cmd_addr[7:0];
      HOFS_ADDR_HI:   d.sw_rdata = {4'h0, q.cmd_addr[11:8]};
      HOFS_WDATA:     d.sw_rdata = q.cmd_wdata;
      HOFS_RDATA:     d.sw_rdata = q.cmd_rdata;
      HOFS_STATUS:    d.sw_rdata = {4'h0, link.irq_high, (q.st != CORE_IDLE) || q.cmd_pend, link.irq,
                                    (q.st >= SVC_RD0)};
      HOFS_SVC_CTRL:  d.sw_rdata = {7'h00, q.auto_svc};
      HOFS_FLAGS0:    d.sw_rdata = q.flags[7:0];
      HOFS_FLAGS1:    d.sw_rdata = q.flags[15:8];
      HOFS_FLAGS2:    d.sw_rdata = q.flags[23:16];
      HOFS_SVC_COUNT: d.sw_rdata = q.svc_count;
      HOFS_IRQ_ID:    d.sw_rdata = {3'h0, q.last_id};
      default:        d.sw_rdata = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign link.addr  = q.bus_addr;
  assign link.wdata = q.bus_wdata;
  assign link.wr    = q.bus_wr;
  assign link.rd    = q.bus_rd;
  assign sw_rdata   = q.sw_rdata;

endmodule

// File: src/irq_ctrl_pkg.sv
// package of constants and types shared by the interrupt controller and the core-side end
// assumes an 8-bit register port with 12-bit byte addresses and a 250 MHz core_clk
package irq_ctrl_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W     = 12;
  localparam int DATA_W     = 8;
  localparam int SRC_N      = 24;
  localparam int LEVEL_N    = 16;
  localparam int EDGE_N     = 8;
  localparam int EDGE_IN_N  = 6;
  localparam int ID_W       = 5;

  // ----------------------------------------------------------------
  // controller register map
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_LEVEL_MASK_LOW  = 12'h640;
  localparam logic [11:0] OFS_LEVEL_MASK_HIGH = 12'h641;
  localparam logic [11:0] OFS_EDGE_MASK       = 12'h642;
  localparam logic [11:0] OFS_GLOBAL_ENABLE   = 12'h643;
  localparam logic [11:0] OFS_PRIORITY_BYTE0  = 12'h644;
  localparam logic [11:0] OFS_PRIORITY_BYTE1  = 12'h645;
  localparam logic [11:0] OFS_PRIORITY_BYTE2  = 12'h646;
  localparam logic [11:0] OFS_SOURCE_FLAGS0   = 12'h648;
  localparam logic [11:0] OFS_SOURCE_FLAGS1   = 12'h649;
  localparam logic [11:0] OFS_SOURCE_FLAGS2   = 12'h64A;

  localparam logic [7:0]  RST_BYTE            = 8'h00;
  localparam int          MODE_ENABLE_BIT     = 0;
  localparam int          MODE_MULTI_BIT      = 1;
  localparam int          BUS_IDLE_BIT        = 16;
  localparam logic [7:0]  EDGE_VALID_MASK     = 8'h7F;

  // ----------------------------------------------------------------
  // bus idle timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS     = 4000;
  localparam int BUS_IDLE_TIME_US  = 250;
  localparam int BUS_IDLE_CYCLES   = (BUS_IDLE_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int IDLE_CNT_W        = 17;

  // ----------------------------------------------------------------
  // core-side end: its own register map
  // ----------------------------------------------------------------
  localparam logic [3:0] HOFS_ADDR_LO   = 4'h0;
  localparam logic [3:0] HOFS_ADDR_HI   = 4'h1;
  localparam logic [3:0] HOFS_WDATA     = 4'h2;
  localparam logic [3:0] HOFS_CMD       = 4'h3;
  localparam logic [3:0] HOFS_RDATA     = 4'h4;
  localparam logic [3:0] HOFS_STATUS    = 4'h5;
  localparam logic [3:0] HOFS_SVC_CTRL  = 4'h6;
  localparam logic [3:0] HOFS_FLAGS0    = 4'h8;
  localparam logic [3:0] HOFS_FLAGS1    = 4'h9;
  localparam logic [3:0] HOFS_FLAGS2    = 4'hA;
  localparam logic [3:0] HOFS_SVC_COUNT = 4'hB;
  localparam logic [3:0] HOFS_IRQ_ID    = 4'hC;

  localparam int CMD_GO_BIT    = 0;
  localparam int CMD_WRITE_BIT = 1;

  typedef enum logic [2:0] {
    CORE_IDLE = 3'b000,
    CORE_CMD  = 3'b001,
    CORE_RDW  = 3'b010,
    SVC_RD0   = 3'b011,
    SVC_RD1   = 3'b100,
    SVC_RD2   = 3'b101,
    SVC_RDW   = 3'b110,
    SVC_CLR   = 3'b111
  } core_state_t;

endpackage

// File: src/irq_link_if.sv
// interface joining the interrupt controller and the processor core end
// assumes both ends share core_clk; read data stand one cycle after the read strobe
`timescale 1ns/10ps
interface irq_link_if;
  import irq_ctrl_pkg::*;

  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr;
  logic              rd;
  logic [DATA_W-1:0] rdata;
  logic              irq;
  logic              irq_high;
  logic [ID_W-1:0]   irq_id;

  modport ctrl (
    input  addr, wdata, wr, rd,
    output rdata, irq, irq_high, irq_id
  );

  modport core (
    output addr, wdata, wr, rd,
    input  rdata, irq, irq_high, irq_id
  );
endinterface

// File: src/irq_mask_priority_controller.sv
// interrupt controller: 23 sources, masks, priority, global enable and source flags
// assumes request inputs synchronous to core_clk and one access strobe per cycle at most
`timescale 1ns/10ps
// Summary of operation
// - sixteen level and seven edge sources
// - mask byte zero gates host through timers
// - mask byte one gates engine through bus
// - mask byte two gates the edge sources
// - bus idle event after idle time
// - zero mask bit suppresses its source
// - mode bit zero is global enable
// - mode bit one stored, no function
// - priority bytes mark sources high or low
// - high priority sources presented first
// - software leaves priority at defaults
// - requesting source sets its flag bit
// - flag word follows mask bit order
// - edge flag held until written one
// - level flag follows source module status
// - software masks, enables, reads, then clears
// - core suspends, services, then resumes
module irq_mask_priority_controller
  import irq_ctrl_pkg::*;
#(
  parameter int IDLE_CYCLES = BUS_IDLE_CYCLES
)
(
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  // level sources: bits 7..0 host, serial, fifo, dma, powerdown, timers 2..0; 15..8 engine..bus
  input  wire logic [LEVEL_N-1:0]   level_req,
  // edge sources: bits 6..1 pin_to_core_events[1:0], system timer, slow timer, pin, bus reset
  input  wire logic [EDGE_IN_N:1]   edge_req,
  // attached bus activity, restarts the idle timer
  input  wire logic                 bus_activity,
  // link to the core
  irq_link_if.ctrl                  link
);

  typedef struct packed {
    logic [SRC_N-1:0]      mask;
    logic [1:0]            mode;
    logic [SRC_N-1:0]      prio;
    logic [LEVEL_N-1:0]    level_flag;
    logic [EDGE_N-1:0]     edge_flag;
    logic [EDGE_IN_N:0]    edge_prev;
    logic [IDLE_CNT_W-1:0] idle_cnt;
    logic [DATA_W-1:0]     rdata;
    logic                  irq;
    logic                  irq_high;
    logic [ID_W-1:0]       irq_id;
  } ctrl_regs_t;

  ctrl_regs_t q, d;

  localparam logic [IDLE_CNT_W-1:0] IDLE_LAST = IDLE_CNT_W'(IDLE_CYCLES - 1);

  logic [EDGE_IN_N:0] edge_in;
  logic               idle_reached;
  logic [SRC_N-1:0]   pend;
  logic [SRC_N-1:0]   pick;
  logic [EDGE_N-1:0]  clr;
  logic [EDGE_N-1:0]  rise;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;

    // idle counter saturates at its last count so the event fires once per idle period
    if (bus_activity) begin
      d.idle_cnt = '0;
    end else if (q.idle_cnt != IDLE_LAST) begin
      d.idle_cnt = q.idle_cnt + 1'b1;
    end
    idle_reached = (q.idle_cnt == IDLE_LAST) && !bus_activity;
    edge_in      = {edge_req, idle_reached};

    if (link.wr) begin
      case (link.addr)
        OFS_LEVEL_MASK_LOW:  d.mask[7:0]   = link.wdata;
        OFS_LEVEL_MASK_HIGH: d.mask[15:8]  = link.wdata;
        OFS_EDGE_MASK:       d.mask[23:16] = link.wdata & EDGE_VALID_MASK;
        OFS_GLOBAL_ENABLE:   d.mode        = link.wdata[MODE_MULTI_BIT:MODE_ENABLE_BIT];
        OFS_PRIORITY_BYTE0:  d.prio[7:0]   = link.wdata;
        OFS_PRIORITY_BYTE1:  d.prio[15:8]  = link.wdata;
        OFS_PRIORITY_BYTE2:  d.prio[23:16] = link.wdata & EDGE_VALID_MASK;
        default: ;
      endcase
    end

    // level flags mirror the source; no register here clears them
    d.level_flag = level_req;
    d.edge_prev  = edge_in;
    clr  = (link.wr && link.addr == OFS_SOURCE_FLAGS2) ? link.wdata : '0;
    rise = {1'b0, edge_in & ~q.edge_prev};
    // a rising edge in the clearing cycle wins over the clear
    d.edge_flag = ((q.edge_flag & ~clr) | rise) & EDGE_VALID_MASK;

    // flag word bit order equals mask bit order
    pend = {d.edge_flag, d.level_flag} & d.mask
           & {SRC_N{d.mode[MODE_ENABLE_BIT]}};
    d.irq      = |pend;
    d.irq_high = |(pend & d.prio);
    pick       = d.irq_high ? (pend & d.prio) : pend;
    d.irq_id   = '0;
    for (int i = SRC_N - 1; i >= 0; i--) begin
      if (pick[i]) begin
        d.irq_id = ID_W'(i);
      end
    end

    // read data stand one cycle after the strobe; unmapped reads give zero
    d.rdata = '0;
    if (link.rd) begin
      case (link.addr)
        OFS_LEVEL_MASK_LOW:  d.rdata = q.mask[7:0];
        OFS_LEVEL_MASK_HIGH: d.rdata = q.mask[15:8];
        OFS_EDGE_MASK:       d.rdata = q.mask[23:16];
        OFS_GLOBAL_ENABLE:   d.rdata = {6'h00, q.mode};
        OFS_PRIORITY_BYTE0:  d.rdata = q.prio[7:0];
        OFS_PRIORITY_BYTE1:  d.rdata = q.prio[15:8];
        OFS_PRIORITY_BYTE2:  d.rdata = q.prio[23:16];
        OFS_SOURCE_FLAGS0:   d.rdata = q.level_flag[7:0];
        OFS_SOURCE_FLAGS1:   d.rdata = q.level_flag[15:8];
        OFS_SOURCE_FLAGS2:   d.rdata = q.edge_flag;
        default:             d.rdata = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign link.rdata    = q.rdata;
  assign link.irq      = q.irq;
  assign link.irq_high = q.irq_high;
  assign link.irq_id   = q.irq_id;

endmodule

// File: verification/irq_link_sva.sv
// checker on the controller-to-core link
// assumes one clock domain and rd, wr never high together
`timescale 1ns/10ps
module irq_link_sva
  import irq_ctrl_pkg::*;
(
  // clock and reset
  input wire logic              core_clk,
  input wire logic              rst_n,
  // link signals
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic              irq,
  input wire logic              irq_high,
  input wire logic [ID_W-1:0]   irq_id
);
  // ----------------------------------------------------------------
  // shadow of the writable bytes
  // ----------------------------------------------------------------
  logic [6:0][7:0] shadow_q;
  logic [7:0]      exp_q;
  logic [23:0]     mask;
  logic [23:0]     prio;
  assign mask = {shadow_q[2], shadow_q[1], shadow_q[0]};
  assign prio = {shadow_q[6], shadow_q[5], shadow_q[4]};
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      shadow_q <= '0;
      exp_q <= 8'h00;
    end else begin
      // captured at the read edge, so a write just before is seen
      exp_q <= shadow_q[addr[2:0]];
      if (wr && addr >= 12'h640 && addr <= 12'h646)
        shadow_q[addr[2:0]] <= wdata & (addr[1:0] == 2'h2 ? 8'h7F : addr == 12'h643 ? 8'h03 : 8'hFF);
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_rd_rw;
    rd && addr >= 12'h640 && addr <= 12'h646;
  endsequence
  sequence s_rd_none;
    rd && (addr < 12'h640 || addr > 12'h64A || addr == 12'h647);
  endsequence
  AST_RD_BACK: assert property (s_rd_rw |=> rdata == exp_q) else $error("readback differs");
  AST_RD_IDLE: assert property (!rd |=> rdata == 8'h00) else $error("rdata not zero");
  AST_UNMAPPED: assert property (s_rd_none |=> rdata == 8'h00) else $error("unmapped read");
  AST_FLAG_RSVD: assert property (rd && addr == OFS_SOURCE_FLAGS2 |=> !rdata[7]) else $error("bit 23 set");
  AST_ENABLE: assert property (!shadow_q[3][0] |-> !irq) else $error("irq while disabled");
  AST_MASK_ID: assert property (irq |-> mask[irq_id]) else $error("masked source chosen");
  AST_HIGH_ID: assert property (irq_high |-> irq && prio[irq_id]) else $error("high not chosen");
  AST_LOW_ID: assert property (irq && !irq_high |-> !prio[irq_id]) else $error("low marked high");
endmodule

// File: verification/irq_mask_priority_controller_tb.sv
// testbench: core end and controller joined by the link
// assumes core end register map of the package, IDLE_CYCLES cut to 8
`timescale 1ns/10ps
`define CHECK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module irq_mask_priority_controller_tb
  import irq_ctrl_pkg::*;
;
  localparam int IDLE_SIM = 8;
  logic        core_clk;
  logic        rst_n;
  logic [15:0] level_req;
  logic [6:1]  edge_req;
  logic        bus_activity;
  logic [3:0]  sw_addr;
  logic [7:0]  sw_wdata;
  logic        sw_wr;
  logic        sw_rd;
  logic [7:0]  sw_rdata;
  logic [7:0]  v;
  int          bad_count = 0;
  int          compares = 0;
  irq_link_if link ();
  irq_mask_priority_controller #(.IDLE_CYCLES(IDLE_SIM)) i_irq_mask_priority_controller (
    .core_clk(core_clk), .rst_n(rst_n), .level_req(level_req), .edge_req(edge_req),
    .bus_activity(bus_activity), .link(link));
  irq_core_end i_irq_core_end (.core_clk(core_clk), .rst_n(rst_n), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .link(link));
  irq_link_sva i_irq_link_sva (.core_clk(core_clk), .rst_n(rst_n), .addr(link.addr),
    .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata), .irq(link.irq),
    .irq_high(link.irq_high), .irq_id(link.irq_id));
  always #2 core_clk = ~core_clk;
  // ----------------------------------------------------------------
  // port tasks
  // ----------------------------------------------------------------
  task automatic sw_put(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge core_clk);
    sw_wr <= 1'b0;
  endtask
  task automatic sw_get(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge core_clk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask
  task automatic ctl_wr(input logic [11:0] a, input logic [7:0] d);
    sw_put(HOFS_ADDR_LO, a[7:0]);
    sw_put(HOFS_ADDR_HI, {4'h0, a[11:8]});
    sw_put(HOFS_WDATA, d);
    sw_put(HOFS_CMD, 8'h03);
    repeat (4) @(posedge core_clk);
    #1;
  endtask
  task automatic ctl_rd(input logic [11:0] a, output logic [7:0] d);
    sw_put(HOFS_ADDR_LO, a[7:0]);
    sw_put(HOFS_ADDR_HI, {4'h0, a[11:8]});
    sw_put(HOFS_CMD, 8'h01);
    repeat (4) @(posedge core_clk);
    sw_get(HOFS_RDATA, d);
  endtask
  task automatic pulse_edges(input logic [6:1] e);
    @(posedge core_clk);
    edge_req <= e;
    @(posedge core_clk);
    edge_req <= 6'h00;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 11; i++) begin
      ctl_rd(12'h640 + 12'(i), v);
      `CHECK(v, RST_BYTE)
    end
  endtask
  task automatic t_rw;
    for (int i = 0; i < 7; i++) begin
      ctl_wr(12'h640 + 12'(i), 8'hFF);
      ctl_rd(12'h640 + 12'(i), v);
      `CHECK(v, (i == 2 || i == 6) ? 8'h7F : (i == 3) ? 8'h03 : 8'hFF)
      ctl_wr(12'h640 + 12'(i), 8'h00);
    end
    // level flag bytes ignore writes
    ctl_wr(OFS_SOURCE_FLAGS0, 8'hFF);
    ctl_rd(OFS_SOURCE_FLAGS0, v);
    `CHECK(v, 8'h00)
  endtask
  task automatic t_level;
    @(posedge core_clk);
    level_req <= 16'h8001;
    ctl_rd(OFS_SOURCE_FLAGS0, v);
    `CHECK(v, 8'h01)
    ctl_rd(OFS_SOURCE_FLAGS1, v);
    `CHECK(v, 8'h80)
    `CHECK(link.irq, 1'b0)
    ctl_wr(OFS_LEVEL_MASK_LOW, 8'h01);
    `CHECK(link.irq, 1'b0)
    ctl_wr(OFS_GLOBAL_ENABLE, 8'h01);
    `CHECK(link.irq, 1'b1)
    @(posedge core_clk);
    level_req <= 16'h0000;
    ctl_rd(OFS_SOURCE_FLAGS0, v);
    `CHECK(v, 8'h00)
    `CHECK(link.irq, 1'b0)
  endtask
  task automatic t_edge;
    pulse_edges(6'h3F);
    ctl_rd(OFS_SOURCE_FLAGS2, v);
    `CHECK(v, 8'h7E)
    `CHECK(link.irq, 1'b0)
    ctl_wr(OFS_EDGE_MASK, 8'h04);
    `CHECK(link.irq, 1'b1)
    ctl_wr(OFS_SOURCE_FLAGS2, 8'h04);
    `CHECK(link.irq, 1'b0)
    ctl_rd(OFS_SOURCE_FLAGS2, v);
    `CHECK(v, 8'h7A)
    ctl_wr(OFS_SOURCE_FLAGS2, 8'h7A);
    ctl_rd(OFS_SOURCE_FLAGS2, v);
    `CHECK(v, 8'h00)
  endtask
  task automatic t_prio;
    @(posedge core_clk);
    level_req <= 16'h0009;
    ctl_wr(OFS_LEVEL_MASK_LOW, 8'h09);
    `CHECK(link.irq_id, 5'h00)
    `CHECK(link.irq_high, 1'b0)
    ctl_wr(OFS_PRIORITY_BYTE0, 8'h08);
    `CHECK(link.irq_id, 5'h03)
    `CHECK(link.irq_high, 1'b1)
    ctl_wr(OFS_PRIORITY_BYTE0, 8'h00);
    @(posedge core_clk);
    level_req <= 16'h0000;
  endtask
  task automatic t_idle;
    ctl_wr(OFS_EDGE_MASK, 8'h01);
    @(posedge core_clk);
    bus_activity <= 1'b0;
    repeat (IDLE_SIM - 2) @(posedge core_clk);
    #1 `CHECK(link.irq, 1'b0)
    repeat (4) @(posedge core_clk);
    #1 `CHECK(link.irq, 1'b1)
    @(posedge core_clk);
    bus_activity <= 1'b1;
    ctl_rd(OFS_SOURCE_FLAGS2, v);
    `CHECK(v, 8'h01)
    ctl_wr(OFS_SOURCE_FLAGS2, 8'h01);
    `CHECK(link.irq, 1'b0)
  endtask
  task automatic t_service;
    ctl_wr(OFS_EDGE_MASK, 8'h02);
    sw_put(HOFS_SVC_CTRL, 8'h01);
    pulse_edges(6'h01);
    repeat (20) @(posedge core_clk);
    sw_get(HOFS_SVC_COUNT, v);
    `CHECK(v, 8'h01)
    sw_get(HOFS_FLAGS2, v);
    `CHECK(v, 8'h02)
    sw_get(HOFS_IRQ_ID, v);
    `CHECK(v, 8'h11)
    `CHECK(link.irq, 1'b0)
  endtask
  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic complete_run;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    level_req = 16'h0000;
    edge_req = 6'h00;
    bus_activity = 1'b1;
    sw_addr = 4'h0;
    sw_wdata = 8'h00;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset;
    t_rw;
    t_level;
    t_edge;
    t_prio;
    t_idle;
    t_service;
    complete_run;
  end
  // about 37x the expected run length
  initial begin
    #100000;
    bad_count++;
    complete_run;
  end
endmodule
